// ---- logic/avw_vendor_widget.sv ----
/*
 * Vendor widget verb decoder of a display audio codec: stream tags, driver mailbox with
 * unsolicited response, vendor configuration, time-code capture, time-code offset and device index.
 * Assumes verbs, counters and the function group reset arrive on the codec link clock.
 */
// Behaviour
// R01 - stream verb bits 7:3 give 5-bit tag
// R02 - bits 2:0 pick which tag entry
// R03 - parameter 09h returns type Fh, rest zero
// R04 - mailbox byte 71Eh, F1Eh returns all bytes
// R05 - verb 728h is clock off, payload ignored
// R06 - bit 7 allows unsolicited response on mailbox
// R07 - unsolicited response carries 6-bit tag
// R08 - vendor config set 781h, get F81h
// R09 - bits 7:4 choose one of nine ports
// R10 - bit 1 enables DP1.2 features
// R11 - bit 0 exposes all pins and converters
// R12 - config survives function group reset
// R13 - verb 782h captures both counters together
// R14 - read returns captured 32-bit time code
// R15 - read returns captured 32-bit wall clock
// R16 - offset loaded by four byte writes
// R17 - F85h returns offset, resets zero
// R18 - device index set 789h, get F89h
// R19 - index bits 5:0 select pipe, reset zero
// R20 - port chosen by four-bit field 7:4
// R21 - F83h time code, F84h wall clock
`include "avw_cfg.svh"
`default_nettype none

module avw_vendor_widget
    import avw_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic fg_reset,
    input wire logic verb_valid,
    input wire avw_verb_t verb_in,
    input wire logic [31:0] time_code_counter,
    input wire logic [31:0] wall_clock_counter,
    output logic resp_valid,
    output logic [31:0] resp_data,
    output logic unsol_valid,
    output logic [5:0] unsol_tag,
    output logic clock_off,
    output avw_tags_t stream_sub_identifier,
    output logic [3:0] port_select,
    output logic dp12_feature_enable,
    output logic expose_all_widgets,
    output logic [8:0] widget_visible,
    output logic [31:0] time_code_offset,
    output logic [5:0] device_index
);

    avw_state_t st;
    avw_state_t next_st;
    logic [7:0] pl;

    assign pl = verb_in.payload;

    always_comb begin
        next_st = st;
        next_st.resp_valid = 1'b0;
        next_st.unsol_valid = 1'b0;
        next_st.clock_off = 1'b0;
        // a function group reset clears volatile state; the vendor configuration is kept
        if (fg_reset) begin
            next_st = '0;
            next_st.vcfg = st.vcfg; // [R12]
        end else if (verb_valid) begin
            next_st.resp_valid = 1'b1;
            next_st.resp_data = `AVW_RESET_WORD;
            case (verb_in.verb)
                `AVW_VERB_GET_PARAM: begin
                    if (pl == `AVW_PARAM_WIDGET_CAPS) begin
                        next_st.resp_data[23:20] = `AVW_WIDGET_TYPE_VENDOR; // [R03]
                    end
                end
                `AVW_VERB_SET_STREAM_ID: begin
                    next_st.entry_index = pl[`AVW_ENTRY_MSB:0]; // [R02]
                    next_st.stream_tags[pl[`AVW_ENTRY_MSB:0]] = pl[`AVW_TAG_MSB:`AVW_TAG_LSB]; // [R01]
                end
                `AVW_VERB_GET_STREAM_ID: begin
                    next_st.resp_data[7:0] = {st.stream_tags[st.entry_index], st.entry_index}; // [R02]
                end
                `AVW_VERB_SET_MBOX_B0: next_st.driver_mailbox[7:0] = pl;
                `AVW_VERB_SET_MBOX_B1: next_st.driver_mailbox[15:8] = pl;
                `AVW_VERB_SET_MBOX_B2: begin
                    next_st.driver_mailbox[23:16] = pl; // [R04]
                    // only writes to this byte raise the unsolicited response
                    next_st.unsol_valid = st.unsolicited_enable; // [R06]
                    next_st.unsol_tag_out = st.unsol_tag; // [R07]
                end
                `AVW_VERB_SET_MBOX_B3: next_st.driver_mailbox[31:24] = pl;
                `AVW_VERB_GET_MBOX: next_st.resp_data = st.driver_mailbox; // [R04]
                `AVW_VERB_CLOCK_OFF: next_st.clock_off = 1'b1; // [R05]
                `AVW_VERB_SET_UNSOL: begin
                    next_st.unsolicited_enable = pl[`AVW_UNSOL_EN_BIT]; // [R06]
                    next_st.unsol_tag = pl[`AVW_UNSOL_TAG_MSB:0]; // [R07]
                end
                `AVW_VERB_GET_UNSOL: begin
                    next_st.resp_data[7:0] = {st.unsolicited_enable, 1'b0, st.unsol_tag};
                end
                `AVW_VERB_SET_VCFG: begin
                    next_st.vcfg.port_select = pl[`AVW_PORT_SEL_MSB:`AVW_PORT_SEL_LSB]; // [R08] [R20]
                    next_st.vcfg.dp12_feature_enable = pl[`AVW_DP12_BIT]; // [R10]
                    next_st.vcfg.expose_all_widgets = pl[`AVW_EXPOSE_ALL_BIT]; // [R11]
                end
                `AVW_VERB_GET_VCFG: begin
                    next_st.resp_data[7:0] = {st.vcfg.port_select, 2'b00,
                        st.vcfg.dp12_feature_enable, st.vcfg.expose_all_widgets}; // [R08]
                end
                `AVW_VERB_CAPTURE: begin
                    next_st.captured_time_code = time_code_counter; // [R13]
                    next_st.captured_wall_clock = wall_clock_counter; // [R13]
                end
                `AVW_VERB_GET_CAP_TC: next_st.resp_data = st.captured_time_code; // [R14] [R21]
                `AVW_VERB_GET_CAP_WC: next_st.resp_data = st.captured_wall_clock; // [R15] [R21]
                `AVW_VERB_GET_OFFSET: next_st.resp_data = st.time_code_offset; // [R17]
                `AVW_VERB_SET_OFFSET_B0: next_st.time_code_offset[7:0] = pl; // [R16]
                `AVW_VERB_SET_OFFSET_B1: next_st.time_code_offset[15:8] = pl; // [R16]
                `AVW_VERB_SET_OFFSET_B2: next_st.time_code_offset[23:16] = pl; // [R16]
                `AVW_VERB_SET_OFFSET_B3: next_st.time_code_offset[31:24] = pl; // [R16]
                `AVW_VERB_SET_DEV_INDEX: next_st.device_index = pl[`AVW_DEV_INDEX_MSB:0]; // [R18] [R19]
                `AVW_VERB_GET_DEV_INDEX: next_st.resp_data[7:0] = {2'b00, st.device_index}; // [R18]
                default: next_st.resp_data = `AVW_RESET_WORD;
            endcase
        end
        // unassigned port codes expose nothing rather than wrapping onto a real port
        if (next_st.vcfg.expose_all_widgets) begin
            next_st.widget_visible = '1; // [R11]
        end else if (next_st.vcfg.port_select < 4'(`AVW_PORT_COUNT)) begin
            next_st.widget_visible = 9'h001 << next_st.vcfg.port_select; // [R09] [R20]
        end else begin
            next_st.widget_visible = 9'h000;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            st <= '0; // [R12] [R17] [R19]
        end else begin
            st <= next_st;
        end
    end

    assign resp_valid = st.resp_valid;
    assign resp_data = st.resp_data;
    assign unsol_valid = st.unsol_valid;
    assign unsol_tag = st.unsol_tag_out;
    assign clock_off = st.clock_off;
    assign stream_sub_identifier = st.stream_tags;
    assign port_select = st.vcfg.port_select;
    assign dp12_feature_enable = st.vcfg.dp12_feature_enable;
    assign expose_all_widgets = st.vcfg.expose_all_widgets;
    assign widget_visible = st.widget_visible;
    assign time_code_offset = st.time_code_offset;
    assign device_index = st.device_index;

endmodule // avw_vendor_widget

`default_nettype wire

// ---- logic/avw_cfg.svh ----
/*
 * Verb codes, field positions and reset values of the vendor widget verb decoder.
 * Assumes 12-bit verb identifiers, each with an 8-bit payload, as carried on the codec link.
 */
`ifndef AVW_CFG_SVH
`define AVW_CFG_SVH

`define AVW_VERB_GET_PARAM 12'hf00
`define AVW_VERB_SET_STREAM_ID 12'h73c
`define AVW_VERB_GET_STREAM_ID 12'hf3c
`define AVW_VERB_SET_MBOX_B0 12'h71c
`define AVW_VERB_SET_MBOX_B1 12'h71d
`define AVW_VERB_SET_MBOX_B2 12'h71e
`define AVW_VERB_SET_MBOX_B3 12'h71f
`define AVW_VERB_GET_MBOX 12'hf1e
`define AVW_VERB_CLOCK_OFF 12'h728
`define AVW_VERB_SET_UNSOL 12'h708
`define AVW_VERB_GET_UNSOL 12'hf08
`define AVW_VERB_SET_VCFG 12'h781
`define AVW_VERB_GET_VCFG 12'hf81
`define AVW_VERB_CAPTURE 12'h782
`define AVW_VERB_GET_CAP_TC 12'hf83
`define AVW_VERB_GET_CAP_WC 12'hf84
`define AVW_VERB_GET_OFFSET 12'hf85
`define AVW_VERB_SET_OFFSET_B0 12'h785
`define AVW_VERB_SET_OFFSET_B1 12'h786
`define AVW_VERB_SET_OFFSET_B2 12'h787
`define AVW_VERB_SET_OFFSET_B3 12'h788
`define AVW_VERB_SET_DEV_INDEX 12'h789
`define AVW_VERB_GET_DEV_INDEX 12'hf89

`define AVW_PARAM_WIDGET_CAPS 8'h09
`define AVW_WIDGET_TYPE_VENDOR 4'hf

`define AVW_TAG_MSB 7
`define AVW_TAG_LSB 3
`define AVW_ENTRY_MSB 2
`define AVW_UNSOL_EN_BIT 7
`define AVW_UNSOL_TAG_MSB 5
`define AVW_PORT_SEL_MSB 7
`define AVW_PORT_SEL_LSB 4
`define AVW_DP12_BIT 1
`define AVW_EXPOSE_ALL_BIT 0
`define AVW_DEV_INDEX_MSB 5
`define AVW_PORT_COUNT 9

`define AVW_RESET_BYTE 8'h00
`define AVW_RESET_WORD 32'h0000_0000

`endif

// ---- logic/avw_pkg.sv ----
/*
 * Types of the vendor widget verb decoder: verb request, stream tag table and the block state.
 * Assumes avw_cfg.svh is on the include path.
 */
`default_nettype none

package avw_pkg;

    typedef struct packed {
        logic [11:0] verb;
        logic [7:0] payload;
    } avw_verb_t;

    typedef logic [7:0][4:0] avw_tags_t;

    typedef struct packed {
        logic [3:0] port_select;
        logic dp12_feature_enable;
        logic expose_all_widgets;
    } avw_vcfg_t;

    typedef struct packed {
        avw_tags_t stream_tags;
        logic [2:0] entry_index;
        logic [31:0] driver_mailbox;
        logic unsolicited_enable;
        logic [5:0] unsol_tag;
        avw_vcfg_t vcfg;
        logic [31:0] captured_time_code;
        logic [31:0] captured_wall_clock;
        logic [31:0] time_code_offset;
        logic [5:0] device_index;
        logic resp_valid;
        logic [31:0] resp_data;
        logic unsol_valid;
        logic [5:0] unsol_tag_out;
        logic clock_off;
        logic [8:0] widget_visible;
    } avw_state_t;

endpackage

`default_nettype wire

// ---- verification/avw_checker_assertions.sv ----
/* port checker of the vendor widget verb decoder
   assumes one clock and the decoder's top ports only */
`default_nettype none
module avw_checker
    import avw_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic fg_reset,
    input wire logic verb_valid,
    input wire avw_verb_t verb_in,
    input wire logic [31:0] time_code_counter,
    input wire logic resp_valid,
    input wire logic [31:0] resp_data,
    input wire logic unsol_valid,
    input wire logic clock_off,
    input wire logic [3:0] port_select,
    input wire logic expose_all_widgets,
    input wire logic [8:0] widget_visible
);
    timeunit 1ns;
    timeprecision 1ps;
    logic take;
    logic [11:0] v;
    assign take = verb_valid && !fg_reset;
    assign v = verb_in.verb;
    default clocking @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    a_resp_follows: assert property (take |=> resp_valid) else $error("no answer");
    a_resp_only: assert property (!take |=> !resp_valid) else $error("stray answer");
    a_clock_off_cmd: assert property (take && v == 12'h728 |=> clock_off) else $error("no clock off");
    a_clock_off_cause: assert property ($rose(clock_off) |-> $past(take && v == 12'h728))
        else $error("stray clock off");
    a_unsol_cause: assert property (unsol_valid |-> $past(take && v == 12'h71e)) else $error("stray unsol");
    a_cfg_survives: assert property (fg_reset |=> $stable({port_select, expose_all_widgets}))
        else $error("config lost");
    a_all_visible: assert property (expose_all_widgets |-> widget_visible == 9'h1ff) else $error("not all");
    a_one_visible: assert property ($past(reset_n) && !expose_all_widgets |->
        widget_visible == (port_select < 4'd9 ? 9'h001 << port_select : 9'h000)) else $error("bad visible");
    a_capture_pair: assert property (take && v == 12'h782 ##1 take && v == 12'hf83 |=>
        resp_data == $past(time_code_counter, 2)) else $error("bad capture");
    c_unsol: cover property (unsol_valid);
    c_clock_off: cover property (clock_off);
    c_keep_cfg: cover property (fg_reset && expose_all_widgets);
endmodule // avw_checker
bind avw_vendor_widget avw_checker chk (.*);
`default_nettype wire

// ---- verification/avw_host_model.sv ----
/* host end of the codec link: issues verbs and collects answers
   assumes an answer one cycle after the take edge */
`default_nettype none
module avw_host_model
    import avw_pkg::*;
(
    input wire logic clk,
    input wire logic resp_valid,
    input wire logic [31:0] resp_data,
    output var logic verb_valid,
    output avw_verb_t verb_in
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        verb_valid = 1'b0;
        verb_in = '0;
    end
    // more keeps the request up so the next verb follows in the very next cycle
    task automatic send(input logic [19:0] vp, input bit more, output logic [32:0] r);
        @(negedge clk);
        verb_valid = 1'b1;
        verb_in = vp;
        @(posedge clk);
        r = '0;
        if (!more) begin
            // the answer pulse stands only for the cycle after the take edge
            @(negedge clk);
            r = {resp_valid, resp_data};
            verb_valid = 1'b0;
            verb_in = ~vp; // a released bus does not keep its last value
        end
    endtask
endmodule // avw_host_model
`default_nettype wire

// ---- verification/testbench.sv ----
/* self-checking bench of the vendor widget verb decoder
   assumes the host model drives the verb port, the bench all else */
`default_nettype none
module testbench
    import avw_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, reset_n, fg_reset, verb_valid, resp_valid, unsol_valid, clock_off, dp12_feature_enable;
    logic expose_all_widgets;
    logic [31:0] time_code_counter, wall_clock_counter, resp_data, time_code_offset;
    logic [5:0] unsol_tag, device_index;
    logic [3:0] port_select;
    logic [8:0] widget_visible;
    logic [32:0] r;
    avw_verb_t verb_in;
    avw_tags_t stream_sub_identifier;
    int errors = 0, tests_run = 0, cycles = 0;
    logic [51:0] rows [21] = '{52'h78153_00000000, 52'hf8100_00000053, 52'hf0009_00f00000, 52'hf000c_00000000,
        52'h73cde_00000000, 52'hf3c00_000000de, 52'h71c11_00000000, 52'h71d22_00000000, 52'h71f44_00000000,
        52'h71e33_00000000, 52'hf1e00_44332211, 52'h785a1_00000000, 52'h786b2_00000000, 52'h787c3_00000000,
        52'h788d4_00000000, 52'hf8500_d4c3b2a1, 52'h78925_00000000, 52'hf8900_00000025, 52'h70885_00000000,
        52'hf0800_00000085, 52'hf7f00_00000000};
    avw_vendor_widget dut (.*);
    avw_host_model host (.*);
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            finish_test();
        end
    end
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        {reset_n, fg_reset, time_code_counter, wall_clock_counter} = '0;
        repeat (10) @(negedge clk);
        reset_n = 1'b1;
        check({time_code_offset, device_index}, 0);
        foreach (rows[i]) begin
            host.send(rows[i][51:32], 1'b0, r);
            check(r, {1'b1, rows[i][31:0]});
        end
        check(stream_sub_identifier[6], 5'h1b);
        $display("table done");
        time_code_counter = 32'h1234_5678;
        wall_clock_counter = 32'h9abc_def0;
        host.send(20'h78277, 1'b1, r);
        host.send(20'hf8300, 1'b0, r);
        check(r, 33'h1_1234_5678);
        time_code_counter = 32'h0;
        host.send(20'hf8400, 1'b0, r);
        check(r, 33'h1_9abc_def0);
        for (int e = 0; e < 2; e++) begin
            host.send({12'h71e, 8'h5a}, 1'b0, r);
            check({unsol_valid, unsol_tag}, e ? 7'h05 : 7'h45);
            host.send(20'h70805, 1'b0, r);
        end
        for (int p = 0; p < 256; p += 255) begin
            host.send({12'h728, 8'(p)}, 1'b0, r);
            check(clock_off, 1'b1);
        end
        $display("capture, unsol, clock off done");
        for (int i = 0; i < 16; i++) begin
            host.send({12'h781, 4'(i), 4'h2}, 1'b0, r);
            check({port_select, dp12_feature_enable, widget_visible},
                {4'(i), 1'b1, i < 9 ? 9'h001 << i : 9'h000});
        end
        host.send(20'h78103, 1'b0, r);
        check({dp12_feature_enable, expose_all_widgets, widget_visible}, {2'b11, 9'h1ff});
        host.send(20'h78577, 1'b0, r);
        host.send(20'h7893f, 1'b0, r);
        @(negedge clk);
        fg_reset = 1'b1;
        repeat (2) @(negedge clk);
        fg_reset = 1'b0;
        check({port_select, dp12_feature_enable, expose_all_widgets}, 6'h03);
        check(time_code_offset, 0);
        check(device_index, 0);
        reset_n = 1'b0;
        repeat (10) @(negedge clk);
        reset_n = 1'b1;
        @(negedge clk);
        check({port_select, dp12_feature_enable, expose_all_widgets, widget_visible}, 9'h001);
        $display("config and resets done");
        finish_test();
    end
endmodule // testbench
`default_nettype wire
